// [hdl/flash_ctrl_pkg.sv]
// Constants for the flash program/erase control block.
// Assumes a 32-bit Avalon-MM slave port with byte addresses.
package flash_ctrl_pkg;
  // Register byte offsets
  localparam logic [3:0] OFS_MODE   = 4'h0;
  localparam logic [3:0] OFS_SETUP  = 4'h4;
  localparam logic [3:0] OFS_ACCESS = 4'h8;

  // Mode control field positions
  localparam int GATE_BIT           = 7;
  localparam int WRITE_ENABLE_BIT   = 6;
  localparam int ERASE_VERIFY_BIT   = 3;
  localparam int PROGRAM_VERIFY_BIT = 2;
  localparam int ERASE_RUN_BIT      = 1;
  localparam int PROGRAM_RUN_BIT    = 0;

  // Setup and error field positions
  localparam int ERROR_FLAG_BIT     = 7;
  localparam int ERASE_SETUP_BIT    = 1;
  localparam int PROGRAM_SETUP_BIT  = 0;

  // Access register field position
  localparam int SELECT_BIT         = 4;

  // Reset values
  localparam logic [7:0] MODE_RESET   = 8'h80;
  localparam logic [7:0] SETUP_RESET  = 8'h00;
  localparam logic [7:0] ACCESS_RESET = 8'h00;
  localparam logic [7:0] DISABLED_READ = 8'h00;
  localparam logic [7:0] ERASED_BYTE  = 8'hff;

  // Erase blocks: four 1 kbyte, then 28, 16, 12 and 2 kbyte
  localparam int NUM_BLOCKS = 8;

  function automatic logic [15:0] block_base(input logic [2:0] idx);
    case (idx)
      3'h0: block_base = 16'h0000;
      3'h1: block_base = 16'h0400;
      3'h2: block_base = 16'h0800;
      3'h3: block_base = 16'h0c00;
      3'h4: block_base = 16'h1000;
      3'h5: block_base = 16'h8000;
      3'h6: block_base = 16'hc000;
      default: block_base = 16'hef80;
    endcase
  endfunction : block_base

  function automatic logic [15:0] block_last(input logic [2:0] idx);
    block_last = (idx == 3'h7) ? 16'hf77f : 16'(block_base(idx + 3'h1) - 16'h0001);
  endfunction : block_last
endpackage : flash_ctrl_pkg

// [hdl/flash_program_erase_control.sv]
// Flash program/erase mode sequencer with its two control registers.
// Assumes an Avalon-MM master, power-state levels from the system
// controller and a one-cycle failure pulse from the array timing logic.
//
// Functional notes
// - Mode control register resets to 80h, also in hardware and software standby.
// - With flash disabled, control registers read 00h and ignore writes.
// - Verify bits are writable only while software write enable is 1.
// - Erase run writable only with gate, software enable and erase setup all 1.
// - Program run writable only with software enable and program setup both 1.
// - Hardware write gate bit 7 is read-only and reads 1.
// - Bits 6 to 2 of the setup register read zero, not writable.
// - Program entry: software enable, then program setup, then program run.
// - Erase entry: software enable, then erase setup, then erase run.
// - Software write enable permits entering either verify mode via its bit.
// - Verify and run bits enter their mode at 1 and leave at 0.
// - Setup register resets to 00h, also in hardware standby.
// - Setup bits clear in software standby, hardware and software protect.
// - Error flag sets on failed program or erase; array then error protected.
// - Error flag clears only on reset, hardware standby or low-power clock modes.
// - Array has erase blocks of 2, 12, 16, 28 and four 1 kbyte.
// - Erase works on whole blocks, erased bytes read FFh.
// - Control registers reachable only while register select bit is 1.
// - Select bit 0 deselects registers but keeps their contents.
`timescale 1ns/100ps
module flash_program_erase_control (
  input  wire logic        clk_in,
  input  wire logic        arst_n_in,
  input  wire logic [3:0]  avs_address_in,
  input  wire logic        avs_read_in,
  input  wire logic        avs_write_in,
  input  wire logic [31:0] avs_writedata_in,
  input  wire logic [3:0]  avs_byteenable_in,
  output logic      [31:0] avs_readdata_out,
  output logic             avs_waitrequest_out,
  input  wire logic        flash_enabled_in,
  input  wire logic        hw_standby_in,
  input  wire logic        sw_standby_in,
  input  wire logic        hw_protect_in,
  input  wire logic        low_power_in,
  input  wire logic        op_fail_in,
  input  wire logic [2:0]  erase_block_in,
  output logic             program_mode_out,
  output logic             erase_mode_out,
  output logic             program_verify_out,
  output logic             erase_verify_out,
  output logic [15:0]      erase_base_out,
  output logic [15:0]      erase_last_out,
  output logic [7:0]       erase_fill_out
);

  logic       software_write_enable;
  logic       erase_verify;
  logic       program_verify;
  logic       erase_run;
  logic       program_run;
  logic       erase_setup;
  logic       program_setup;
  logic       flash_error_flag;
  logic       ctrl_reg_select;
  logic       request;
  logic       accept;
  logic       flash_ok;
  logic       wr_mode;
  logic       wr_setup;
  logic       wr_access;
  logic       standby;
  logic [7:0] wbyte;
  logic [7:0] mode_value;
  logic [7:0] setup_value;

  // Hardware write gate is fixed at 1
  localparam logic write_gate_hw = 1'b1;

  assign request   = avs_read_in | avs_write_in;
  assign accept    = request & ~avs_waitrequest_out;
  assign flash_ok  = flash_enabled_in & ctrl_reg_select;
  assign wbyte     = avs_writedata_in[7:0];
  assign standby   = hw_standby_in | sw_standby_in;
  assign wr_mode   = accept & avs_write_in & avs_byteenable_in[0] & flash_ok
                     & (avs_address_in == flash_ctrl_pkg::OFS_MODE);
  assign wr_setup  = accept & avs_write_in & avs_byteenable_in[0] & flash_ok
                     & (avs_address_in == flash_ctrl_pkg::OFS_SETUP);
  assign wr_access = accept & avs_write_in & avs_byteenable_in[0]
                     & (avs_address_in == flash_ctrl_pkg::OFS_ACCESS);

  always_comb begin
    mode_value = 8'h00;
    mode_value[flash_ctrl_pkg::GATE_BIT]           = write_gate_hw;
    mode_value[flash_ctrl_pkg::WRITE_ENABLE_BIT]   = software_write_enable;
    mode_value[flash_ctrl_pkg::ERASE_VERIFY_BIT]   = erase_verify;
    mode_value[flash_ctrl_pkg::PROGRAM_VERIFY_BIT] = program_verify;
    mode_value[flash_ctrl_pkg::ERASE_RUN_BIT]      = erase_run;
    mode_value[flash_ctrl_pkg::PROGRAM_RUN_BIT]    = program_run;
  end

  always_comb begin
    setup_value = 8'h00;
    setup_value[flash_ctrl_pkg::ERROR_FLAG_BIT]    = flash_error_flag;
    setup_value[flash_ctrl_pkg::ERASE_SETUP_BIT]   = erase_setup;
    setup_value[flash_ctrl_pkg::PROGRAM_SETUP_BIT] = program_setup;
  end

  // One wait cycle, then a single ready cycle per request
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      avs_waitrequest_out <= 1'b1;
    end else if (request && avs_waitrequest_out) begin
      avs_waitrequest_out <= 1'b0;
    end else begin
      avs_waitrequest_out <= 1'b1;
    end
  end

  // Read data is captured in the cycle waitrequest drops
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      avs_readdata_out <= 32'h0000_0000;
    end else if (avs_read_in && avs_waitrequest_out) begin
      unique case (avs_address_in)
        flash_ctrl_pkg::OFS_MODE:
          avs_readdata_out <= {24'h00_0000,
                               flash_ok ? mode_value : flash_ctrl_pkg::DISABLED_READ};
        flash_ctrl_pkg::OFS_SETUP:
          avs_readdata_out <= {24'h00_0000,
                               flash_ok ? setup_value : flash_ctrl_pkg::DISABLED_READ};
        flash_ctrl_pkg::OFS_ACCESS:
          avs_readdata_out <= {27'h000_0000, ctrl_reg_select, 4'h0};
        default:
          avs_readdata_out <= 32'h0000_0000;
      endcase
    end
  end

  // Register select; kept over software standby
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      ctrl_reg_select <= flash_ctrl_pkg::ACCESS_RESET[flash_ctrl_pkg::SELECT_BIT];
    end else if (hw_standby_in) begin
      ctrl_reg_select <= flash_ctrl_pkg::ACCESS_RESET[flash_ctrl_pkg::SELECT_BIT];
    end else if (wr_access) begin
      ctrl_reg_select <= wbyte[flash_ctrl_pkg::SELECT_BIT];
    end
  end

  // Mode control bits; each gated bit updates on its own
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      software_write_enable <= flash_ctrl_pkg::MODE_RESET[flash_ctrl_pkg::WRITE_ENABLE_BIT];
      erase_verify          <= flash_ctrl_pkg::MODE_RESET[flash_ctrl_pkg::ERASE_VERIFY_BIT];
      program_verify        <= flash_ctrl_pkg::MODE_RESET[flash_ctrl_pkg::PROGRAM_VERIFY_BIT];
      erase_run             <= flash_ctrl_pkg::MODE_RESET[flash_ctrl_pkg::ERASE_RUN_BIT];
      program_run           <= flash_ctrl_pkg::MODE_RESET[flash_ctrl_pkg::PROGRAM_RUN_BIT];
    end else if (standby) begin
      software_write_enable <= flash_ctrl_pkg::MODE_RESET[flash_ctrl_pkg::WRITE_ENABLE_BIT];
      erase_verify          <= flash_ctrl_pkg::MODE_RESET[flash_ctrl_pkg::ERASE_VERIFY_BIT];
      program_verify        <= flash_ctrl_pkg::MODE_RESET[flash_ctrl_pkg::PROGRAM_VERIFY_BIT];
      erase_run             <= flash_ctrl_pkg::MODE_RESET[flash_ctrl_pkg::ERASE_RUN_BIT];
      program_run           <= flash_ctrl_pkg::MODE_RESET[flash_ctrl_pkg::PROGRAM_RUN_BIT];
    end else if (wr_mode) begin
      software_write_enable <= wbyte[flash_ctrl_pkg::WRITE_ENABLE_BIT];
      if (software_write_enable) begin
        erase_verify   <= wbyte[flash_ctrl_pkg::ERASE_VERIFY_BIT];
        program_verify <= wbyte[flash_ctrl_pkg::PROGRAM_VERIFY_BIT];
      end
      if (write_gate_hw && software_write_enable && erase_setup) begin
        erase_run <= wbyte[flash_ctrl_pkg::ERASE_RUN_BIT];
      end
      if (software_write_enable && program_setup) begin
        program_run <= wbyte[flash_ctrl_pkg::PROGRAM_RUN_BIT];
      end
    end
  end

  // Setup bits; cleared in standby and in either protect mode
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      erase_setup   <= flash_ctrl_pkg::SETUP_RESET[flash_ctrl_pkg::ERASE_SETUP_BIT];
      program_setup <= flash_ctrl_pkg::SETUP_RESET[flash_ctrl_pkg::PROGRAM_SETUP_BIT];
    end else if (standby || hw_protect_in || !software_write_enable) begin
      erase_setup   <= flash_ctrl_pkg::SETUP_RESET[flash_ctrl_pkg::ERASE_SETUP_BIT];
      program_setup <= flash_ctrl_pkg::SETUP_RESET[flash_ctrl_pkg::PROGRAM_SETUP_BIT];
    end else if (wr_setup) begin
      erase_setup   <= wbyte[flash_ctrl_pkg::ERASE_SETUP_BIT];
      program_setup <= wbyte[flash_ctrl_pkg::PROGRAM_SETUP_BIT];
    end
  end

  // Error flag: a failure in the clearing cycle still sets it
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      flash_error_flag <= flash_ctrl_pkg::SETUP_RESET[flash_ctrl_pkg::ERROR_FLAG_BIT];
    end else if (op_fail_in) begin
      flash_error_flag <= 1'b1;
    end else if (hw_standby_in || low_power_in) begin
      flash_error_flag <= 1'b0;
    end
  end

  // Mode outputs toward the array; runs held off under error protection
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      program_mode_out   <= 1'b0;
      erase_mode_out     <= 1'b0;
      program_verify_out <= 1'b0;
      erase_verify_out   <= 1'b0;
    end else begin
      program_mode_out   <= program_run & ~flash_error_flag;
      erase_mode_out     <= erase_run & ~flash_error_flag;
      program_verify_out <= program_verify;
      erase_verify_out   <= erase_verify;
    end
  end

  // Erase always spans the whole selected block, filled with FFh
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      erase_base_out <= 16'h0000;
      erase_last_out <= 16'h0000;
      erase_fill_out <= flash_ctrl_pkg::ERASED_BYTE;
    end else begin
      erase_base_out <= flash_ctrl_pkg::block_base(erase_block_in);
      erase_last_out <= flash_ctrl_pkg::block_last(erase_block_in);
      erase_fill_out <= flash_ctrl_pkg::ERASED_BYTE;
    end
  end

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!arst_n_in);

  sequence s_program_write;
    wr_mode && !standby && software_write_enable && program_setup
      && wbyte[flash_ctrl_pkg::PROGRAM_RUN_BIT] && !flash_error_flag && !op_fail_in;
  endsequence
  sequence s_program_active;
    program_run ##1 program_mode_out;
  endsequence
  sequence s_erase_write;
    wr_mode && !standby && software_write_enable && erase_setup
      && wbyte[flash_ctrl_pkg::ERASE_RUN_BIT] && !flash_error_flag && !op_fail_in;
  endsequence
  sequence s_erase_active;
    erase_run ##1 erase_mode_out;
  endsequence

  property p_standby_mode_reset;
    standby |=> (mode_value == flash_ctrl_pkg::MODE_RESET);
  endproperty
  a_standby_mode_reset: assert property (p_standby_mode_reset)
    else $error("Mode control not 80h after standby");

  property p_disabled_read_zero;
    (avs_read_in && avs_waitrequest_out && !flash_ok
      && avs_address_in != flash_ctrl_pkg::OFS_ACCESS) |=> (avs_readdata_out == 32'h0000_0000);
  endproperty
  a_disabled_read_zero: assert property (p_disabled_read_zero)
    else $error("Deselected control register read not zero");

  property p_verify_needs_swe;
    (wr_mode && !software_write_enable && !standby)
      |=> ($stable(erase_verify) && $stable(program_verify));
  endproperty
  a_verify_needs_swe: assert property (p_verify_needs_swe)
    else $error("Verify bit changed without software write enable");

  property p_erase_run_gate;
    $rose(erase_run) |-> $past(wr_mode && software_write_enable && erase_setup);
  endproperty
  a_erase_run_gate: assert property (p_erase_run_gate)
    else $error("Erase run set without setup and enable");

  property p_program_run_gate;
    $rose(program_run) |-> $past(wr_mode && software_write_enable && program_setup);
  endproperty
  a_program_run_gate: assert property (p_program_run_gate)
    else $error("Program run set without setup and enable");

  property p_gate_reads_one;
    (avs_read_in && avs_waitrequest_out && flash_ok
      && avs_address_in == flash_ctrl_pkg::OFS_MODE) |=> avs_readdata_out[7];
  endproperty
  a_gate_reads_one: assert property (p_gate_reads_one)
    else $error("Write gate bit read as zero");

  property p_setup_reserved_zero;
    (avs_read_in && avs_waitrequest_out
      && avs_address_in == flash_ctrl_pkg::OFS_SETUP) |=> (avs_readdata_out[6:2] == 5'h00);
  endproperty
  a_setup_reserved_zero: assert property (p_setup_reserved_zero)
    else $error("Reserved setup bits read nonzero");

  property p_program_entry;
    s_program_write |=> s_program_active;
  endproperty
  a_program_entry: assert property (p_program_entry)
    else $error("Program mode not entered after gated run write");

  property p_protect_clears_setup;
    (hw_protect_in || sw_standby_in) |=> (!erase_setup && !program_setup);
  endproperty
  a_protect_clears_setup: assert property (p_protect_clears_setup)
    else $error("Setup bits survived protect or standby");

  property p_error_sets;
    op_fail_in |=> flash_error_flag ##1 (!program_mode_out && !erase_mode_out);
  endproperty
  a_error_sets: assert property (p_error_sets)
    else $error("Error flag or protection missing after failure");

  property p_error_clear_cause;
    $fell(flash_error_flag) |-> $past(hw_standby_in || low_power_in);
  endproperty
  a_error_clear_cause: assert property (p_error_clear_cause)
    else $error("Error flag cleared without a clearing mode");

  property p_deselect_keeps;
    (!ctrl_reg_select && !standby && !hw_protect_in && software_write_enable)
      |=> ($stable(mode_value) && $stable(erase_setup) && $stable(program_setup));
  endproperty
  a_deselect_keeps: assert property (p_deselect_keeps)
    else $error("Deselected registers changed");

  property p_error_blocks_run;
    flash_error_flag |=> (!program_mode_out && !erase_mode_out);
  endproperty
  a_error_blocks_run: assert property (p_error_blocks_run)
    else $error("Run reached the array under error protection");

  property p_erase_entry;
    s_erase_write |=> s_erase_active;
  endproperty
  a_erase_entry: assert property (p_erase_entry)
    else $error("Erase mode not entered after gated run write");

  property p_setup_needs_swe;
    !software_write_enable |=> (!erase_setup && !program_setup);
  endproperty
  a_setup_needs_swe: assert property (p_setup_needs_swe)
    else $error("Setup bit held without software write enable");

  property p_verify_outputs;
    1'b1 |=> (erase_verify_out == $past(erase_verify)
              && program_verify_out == $past(program_verify));
  endproperty
  a_verify_outputs: assert property (p_verify_outputs)
    else $error("Verify output does not follow its bit");

endmodule : flash_program_erase_control

// [dv/flash_program_erase_control_bench.sv]
// Self-checking bench for the flash program/erase control block.
// Assumes the design's own assertions; drives the Avalon-MM port directly.
`timescale 1ns/100ps
`define CHK(nm, exp, got) begin samples_checked++; if ((got) !== (exp)) begin err_count++; \
  $display("FAIL %s expected %h seen %h", nm, exp, got); end end
module flash_program_erase_control_bench;
  logic        clk_in;
  logic        arst_n_in;
  logic [3:0]  avs_address_in;
  logic        avs_read_in;
  logic        avs_write_in;
  logic [31:0] avs_writedata_in;
  logic [3:0]  avs_byteenable_in;
  logic [31:0] avs_readdata_out;
  logic        avs_waitrequest_out;
  logic        flash_enabled_in;
  logic        hw_standby_in;
  logic        sw_standby_in;
  logic        hw_protect_in;
  logic        low_power_in;
  logic        op_fail_in;
  logic [2:0]  erase_block_in;
  logic        program_mode_out;
  logic        erase_mode_out;
  logic        program_verify_out;
  logic        erase_verify_out;
  logic [15:0] erase_base_out;
  logic [15:0] erase_last_out;
  logic [7:0]  erase_fill_out;
  int          err_count;
  int          samples_checked;
  localparam logic [3:0] MD = flash_ctrl_pkg::OFS_MODE;
  localparam logic [3:0] SU = flash_ctrl_pkg::OFS_SETUP;
  localparam logic [3:0] AC = flash_ctrl_pkg::OFS_ACCESS;
  localparam int LV_FAIL = 0;
  localparam int LV_SWSB = 1;
  localparam int LV_LOWP = 2;
  localparam int LV_PROT = 3;
  localparam int LV_HWSB = 4;
  localparam logic [15:0] BASES [8] = '{16'h0000, 16'h0400, 16'h0800, 16'h0c00,
                                        16'h1000, 16'h8000, 16'hc000, 16'hef80};
  localparam logic [15:0] LASTS [8] = '{16'h03ff, 16'h07ff, 16'h0bff, 16'h0fff,
                                        16'h7fff, 16'hbfff, 16'hef7f, 16'hf77f};

  flash_program_erase_control u_flash_program_erase_control (
    .clk_in              (clk_in),
    .arst_n_in           (arst_n_in),
    .avs_address_in      (avs_address_in),
    .avs_read_in         (avs_read_in),
    .avs_write_in        (avs_write_in),
    .avs_writedata_in    (avs_writedata_in),
    .avs_byteenable_in   (avs_byteenable_in),
    .avs_readdata_out    (avs_readdata_out),
    .avs_waitrequest_out (avs_waitrequest_out),
    .flash_enabled_in    (flash_enabled_in),
    .hw_standby_in       (hw_standby_in),
    .sw_standby_in       (sw_standby_in),
    .hw_protect_in       (hw_protect_in),
    .low_power_in        (low_power_in),
    .op_fail_in          (op_fail_in),
    .erase_block_in      (erase_block_in),
    .program_mode_out    (program_mode_out),
    .erase_mode_out      (erase_mode_out),
    .program_verify_out  (program_verify_out),
    .erase_verify_out    (erase_verify_out),
    .erase_base_out      (erase_base_out),
    .erase_last_out      (erase_last_out),
    .erase_fill_out      (erase_fill_out)
  );

  initial clk_in = 1'b0;
  always #5 clk_in = ~clk_in;

  // One bus cycle; request held until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [3:0] a, input logic [7:0] d,
                     output logic [7:0] q);
    int n;
    n = 0;
    @(posedge clk_in);
    avs_address_in   <= a;
    avs_writedata_in <= {24'h000000, d};
    avs_read_in      <= ~wr;
    avs_write_in     <= wr;
    do begin
      @(posedge clk_in);
      n++;
    end while (avs_waitrequest_out !== 1'b0 && n < 50);
    if (n >= 50) `CHK("waitrequest", 1'b0, avs_waitrequest_out)
    q = avs_readdata_out[7:0];
    avs_read_in  <= 1'b0;
    avs_write_in <= 1'b0;
  endtask : bus

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    logic [7:0] q;
    bus(1'b1, a, d, q);
  endtask : wr

  task automatic rd(input logic [3:0] a, input logic [7:0] exp);
    logic [7:0] q;
    bus(1'b0, a, 8'h00, q);
    `CHK("register read", exp, q)
  endtask : rd

  // Holds one level input high for len cycles, then lets three pass
  task automatic pulse(input int sel, input int len);
    @(posedge clk_in);
    drive_level(sel, 1'b1);
    repeat (len) @(posedge clk_in);
    drive_level(sel, 1'b0);
    repeat (3) @(posedge clk_in);
  endtask : pulse

  task automatic drive_level(input int sel, input logic v);
    case (sel)
      LV_FAIL: op_fail_in    <= v;
      LV_SWSB: sw_standby_in <= v;
      LV_LOWP: low_power_in  <= v;
      LV_PROT: hw_protect_in <= v;
      default: hw_standby_in <= v;
    endcase
  endtask : drive_level

  task automatic t_select();
    rd(MD, 8'h00);
    wr(AC, 8'h10);
    rd(MD, 8'h80);
    rd(SU, 8'h00);
  endtask : t_select

  task automatic t_gating();
    wr(MD, 8'h08);
    rd(MD, 8'h80);
    wr(SU, 8'h01);
    rd(SU, 8'h00);
    wr(MD, 8'h00);
    rd(MD, 8'h80);
    wr(MD, 8'h40);
    wr(MD, 8'h42);
    wr(MD, 8'h41);
    rd(MD, 8'hc0);
  endtask : t_gating

  task automatic t_modes();
    wr(SU, 8'hfd);
    rd(SU, 8'h01);
    wr(MD, 8'h41);
    rd(MD, 8'hc1);
    `CHK("program_mode", 1'b1, program_mode_out)
    wr(MD, 8'h40);
    repeat (2) @(posedge clk_in);
    `CHK("program_mode", 1'b0, program_mode_out)
    wr(SU, 8'h02);
    wr(MD, 8'h42);
    repeat (2) @(posedge clk_in);
    `CHK("erase_mode", 1'b1, erase_mode_out)
    wr(MD, 8'h48);
    repeat (2) @(posedge clk_in);
    `CHK("erase_verify", 1'b1, erase_verify_out)
    wr(MD, 8'h44);
    repeat (2) @(posedge clk_in);
    `CHK("program_verify", 1'b1, program_verify_out)
    `CHK("erase_verify", 1'b0, erase_verify_out)
  endtask : t_modes

  task automatic t_error();
    wr(MD, 8'h42);
    pulse(LV_FAIL, 1);
    rd(SU, 8'h82);
    `CHK("erase_mode", 1'b0, erase_mode_out)
    wr(SU, 8'h00);
    rd(SU, 8'h80);
    pulse(LV_SWSB, 2);
    rd(MD, 8'h80);
    rd(SU, 8'h80);
    pulse(LV_LOWP, 2);
    rd(SU, 8'h00);
    wr(MD, 8'h40);
    wr(SU, 8'h01);
    pulse(LV_PROT, 2);
    rd(SU, 8'h00);
    pulse(LV_FAIL, 1);
    pulse(LV_HWSB, 2);
    wr(AC, 8'h10);
    rd(SU, 8'h00);
    rd(MD, 8'h80);
  endtask : t_error

  task automatic t_access();
    wr(MD, 8'h40);
    @(posedge clk_in);
    flash_enabled_in <= 1'b0;
    rd(MD, 8'h00);
    wr(MD, 8'h00);
    @(posedge clk_in);
    flash_enabled_in <= 1'b1;
    rd(MD, 8'hc0);
    wr(AC, 8'h00);
    rd(MD, 8'h00);
    wr(MD, 8'h00);
    wr(AC, 8'h10);
    rd(MD, 8'hc0);
  endtask : t_access

  task automatic t_blocks();
    for (int i = 0; i < 8; i++) begin
      @(posedge clk_in);
      erase_block_in <= 3'(i);
      repeat (2) @(posedge clk_in);
      `CHK("erase_base", BASES[i], erase_base_out)
      `CHK("erase_last", LASTS[i], erase_last_out)
    end
    `CHK("erase_fill", 8'hff, erase_fill_out)
  endtask : t_blocks

  task automatic summarize();
    if (err_count == 0 && samples_checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : summarize

  initial begin
    err_count = 0;
    samples_checked = 0;
    arst_n_in = 1'b0;
    avs_address_in = 4'h0;
    avs_read_in = 1'b0;
    avs_write_in = 1'b0;
    avs_writedata_in = 32'h00000000;
    avs_byteenable_in = 4'hf;
    flash_enabled_in = 1'b1;
    hw_standby_in = 1'b0;
    sw_standby_in = 1'b0;
    hw_protect_in = 1'b0;
    low_power_in = 1'b0;
    op_fail_in = 1'b0;
    erase_block_in = 3'h0;
    repeat (12) @(posedge clk_in);
    arst_n_in <= 1'b1;
    t_select();
    t_gating();
    t_modes();
    t_error();
    t_access();
    t_blocks();
    summarize();
  end

  // Whole run takes well under a thousand cycles
  initial begin
    #100000;
    err_count++;
    summarize();
  end
endmodule : flash_program_erase_control_bench
